/* File: logic/sbcirq_top.sv */
// Interrupt pulse generator, fail-safe readback and serial frame logic
`timescale 1ns/1ps
`default_nettype none
module sbcirq_top #(
   parameter logic SECOND_SAFE_PRESENT = 1'b1
) (
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic mosi_in,
   output logic miso_out,
   output logic miso_oe_out,
   input wire logic init_phase_in,
   input wire logic [7:0] global_flags_in,
   input wire logic deep_safe_hw_in,
   input wire logic ext_pass_fitted_in,
   input wire logic battery_low_in,
   input wire logic supply_low_in,
   input wire logic prereg_boost_in,
   input wire logic prereg_active_in,
   input wire logic clim_expire_analog_in,
   input wire logic clim_expire_aux_in,
   input wire logic tsd_analog_in,
   input wire logic tsd_aux_in,
   input wire logic pass_warn_in,
   input wire logic tsd_transceiver_in,
   input wire logic [4:0] io_state_in,
   input wire logic [4:0] io_wake_in,
   input wire logic aux_uv_in,
   output logic irq_pulse_n_out,
   output logic aux_uv_reset_req_out,
   output logic aux_uv_failsafe_req_out,
   output logic transceiver_enable_out,
   output logic [1:0] aux_uv_impact_sel_out,
   output logic [1:0] aux_ov_impact_sel_out
);
   // ---------------- Link clock domain ----------------
   logic fresh_r;
   logic lead_r;
   logic [4:0] count_r;
   logic [15:0] rx_r;
   logic miso_q_r;
   logic [15:0] out_word_r;
   logic [4:0] next_idx;

   // Fresh flag marks a frame not yet clocked; chip select high rearms it
   always_ff @(posedge sclk_in or posedge cs_n_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fresh_r <= 1'b1;
      end else if (cs_n_in) begin
         fresh_r <= 1'b1;
      end else begin
         fresh_r <= 1'b0;
      end
   end

   // Count and shift; count survives chip select so the main side can read it
   always_ff @(posedge sclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         count_r <= 5'h00;
         rx_r <= 16'h0000;
      end else begin
         rx_r <= {rx_r[14:0], mosi_in};
         if (fresh_r) begin
            count_r <= 5'h01;
         end else if (count_r != sbcirq_pkg::COUNT_MAX) begin
            count_r <= count_r + 5'h01;
         end
      end
   end

   // Next answer bit launched on the falling edge
   assign next_idx = 5'h0F - count_r;
   always_ff @(negedge sclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         miso_q_r <= 1'b0;
      end else if (count_r < sbcirq_pkg::FRAME_BITS) begin
         miso_q_r <= out_word_r[next_idx[3:0]];
      end else begin
         miso_q_r <= 1'b0;
      end
   end

   // Bypass holds bit 15 through its sampling edge, up to the first falling edge
   always_ff @(negedge sclk_in or posedge cs_n_in or negedge rstn_in) begin
      if (!rstn_in) begin
         lead_r <= 1'b1;
      end else if (cs_n_in) begin
         lead_r <= 1'b1;
      end else begin
         lead_r <= 1'b0;
      end
   end

   // First bit must be present before any clock edge, hence the bypass
   assign miso_out = lead_r ? out_word_r[15] : miso_q_r;
   assign miso_oe_out = ~cs_n_in;

   // ---------------- Main clock domain ----------------
   logic [sbcirq_pkg::NSYNC-1:0] async_vec;
   logic [sbcirq_pkg::NSYNC-1:0] s1_r;
   logic [sbcirq_pkg::NSYNC-1:0] s2_r;
   logic [sbcirq_pkg::NSYNC-1:0] s3_r;
   logic [sbcirq_pkg::NSYNC-1:0] st_r;
   logic [sbcirq_pkg::NSYNC-1:0] st_nxt;
   logic [sbcirq_pkg::NSYNC-1:0] rise;
   logic [sbcirq_pkg::NSYNC-1:0] fall;
   logic [sbcirq_pkg::NSYNC-1:0] chg;

   assign async_vec = {cs_n_in, aux_uv_in, io_wake_in, io_state_in, tsd_transceiver_in,
                       pass_warn_in, tsd_aux_in, tsd_analog_in, clim_expire_aux_in,
                       clim_expire_analog_in, prereg_active_in, prereg_boost_in,
                       supply_low_in, battery_low_in};

   // Three-stage synchroniser; a bit moves only once stages two and three agree
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s1_r <= sbcirq_pkg::SYNC_RESET;
         s2_r <= sbcirq_pkg::SYNC_RESET;
         s3_r <= sbcirq_pkg::SYNC_RESET;
         st_r <= sbcirq_pkg::SYNC_RESET;
      end else begin
         s1_r <= async_vec;
         s2_r <= s1_r;
         s3_r <= s2_r;
         st_r <= st_nxt;
      end
   end

   always_comb begin
      st_nxt = st_r;
      for (int i = 0; i < sbcirq_pkg::NSYNC; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            st_nxt[i] = s3_r[i];
         end
      end
   end

   assign rise = st_nxt & ~st_r;
   assign fall = ~st_nxt & st_r;
   assign chg = st_nxt ^ st_r;

   // Straps caught once, just after reset release
   logic strap_done_r;
   logic deep_safe_hw_flag_r;
   logic ext_pass_r;
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         strap_done_r <= 1'b0;
         deep_safe_hw_flag_r <= 1'b0;
         ext_pass_r <= 1'b0;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'b1;
         deep_safe_hw_flag_r <= deep_safe_hw_in;
         ext_pass_r <= ext_pass_fitted_in;
      end
   end

   // Readback word; frozen while a frame runs so the link sees a steady word
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         out_word_r <= 16'h0000;
      end else if (st_r[sbcirq_pkg::S_CS]) begin
         out_word_r <= 16'h0000;
         out_word_r[15:sbcirq_pkg::RB_GLOBAL_LSB] <= global_flags_in;
         out_word_r[sbcirq_pkg::RB_DEEP_BIT] <= deep_safe_hw_flag_r;
         out_word_r[sbcirq_pkg::RB_FS1_BIT] <= SECOND_SAFE_PRESENT;
      end
   end

   // End of frame: link side is idle, its count and word are quiet
   logic frame_end;
   logic frame_ok;
   logic [6:0] cmd;
   logic secure_ok;
   assign frame_end = rise[sbcirq_pkg::S_CS];
   assign frame_ok = frame_end && (count_r == sbcirq_pkg::FRAME_BITS);
   assign cmd = rx_r[sbcirq_pkg::CMD_MSB:sbcirq_pkg::CMD_LSB];
   assign secure_ok = (rx_r[sbcirq_pkg::SEC3] == ~rx_r[sbcirq_pkg::SEC_B5]) &&
                      (rx_r[sbcirq_pkg::SEC2] == ~rx_r[sbcirq_pkg::SEC_B4]) &&
                      (rx_r[sbcirq_pkg::SEC1] == rx_r[sbcirq_pkg::SEC_B7]) &&
                      (rx_r[sbcirq_pkg::SEC0] == rx_r[sbcirq_pkg::SEC_B6]);

   // Impact field; init-phase writes only, bad check bits leave it alone
   logic [1:0] aux_uv_impact_sel_r;
   logic [1:0] aux_ov_impact_sel_r;
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         aux_uv_impact_sel_r <= sbcirq_pkg::IMPACT_RESET;
         aux_ov_impact_sel_r <= sbcirq_pkg::IMPACT_RESET;
      end else if (frame_ok && init_phase_in && cmd == sbcirq_pkg::AUX_WR_CMD && secure_ok) begin
         aux_uv_impact_sel_r <= rx_r[sbcirq_pkg::AUX_UV_LSB+:2];
         aux_ov_impact_sel_r <= rx_r[sbcirq_pkg::AUX_OV_LSB+:2];
      end
   end
   assign aux_uv_impact_sel_out = aux_uv_impact_sel_r;
   assign aux_ov_impact_sel_out = aux_ov_impact_sel_r;

   // Undervoltage routed to reset and fail-safe requests
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         aux_uv_reset_req_out <= 1'b0;
         aux_uv_failsafe_req_out <= 1'b0;
      end else begin
         aux_uv_reset_req_out <= st_r[sbcirq_pkg::S_AUXUV] &
                                 aux_uv_impact_sel_r[sbcirq_pkg::IMPACT_RST_BIT];
         aux_uv_failsafe_req_out <= st_r[sbcirq_pkg::S_AUXUV] &
                                    aux_uv_impact_sel_r[sbcirq_pkg::IMPACT_FS_BIT];
      end
   end

   // Transceiver supply off while hot; comparator hysteresis sets restart point
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         transceiver_enable_out <= 1'b1;
      end else begin
         transceiver_enable_out <= ~st_r[sbcirq_pkg::S_TSDT];
      end
   end

   // Mask and pulse configuration, writable in init phase only
   logic [7:0] mask_r;
   logic [2:0] cfg_r;
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mask_r <= sbcirq_pkg::MASK_RESET;
         cfg_r <= sbcirq_pkg::CFG_RESET;
      end else if (frame_ok && init_phase_in) begin
         if (cmd == sbcirq_pkg::MASK_WR_CMD) begin
            mask_r <= rx_r[7:0];
         end
         if (cmd == sbcirq_pkg::CFG_WR_CMD) begin
            cfg_r <= rx_r[2:0];
         end
      end
   end

   // Event grouping; a mask bit of one silences its whole group
   logic [7:0] grp;
   logic any_event;
   always_comb begin
      grp = 8'h00;
      grp[sbcirq_pkg::MG_SUPPLY] = rise[sbcirq_pkg::S_BATT] | rise[sbcirq_pkg::S_SUPP];
      grp[sbcirq_pkg::MG_PREREG] = chg[sbcirq_pkg::S_BOOST] | chg[sbcirq_pkg::S_PACT];
      grp[sbcirq_pkg::MG_CLIM] = ext_pass_r &
                                 (rise[sbcirq_pkg::S_CLIMA] | rise[sbcirq_pkg::S_CLIMX]);
      grp[sbcirq_pkg::MG_THERM] = rise[sbcirq_pkg::S_TSDA] | rise[sbcirq_pkg::S_TSDX] |
                                  rise[sbcirq_pkg::S_WARN];
      grp[sbcirq_pkg::MG_TRX] = rise[sbcirq_pkg::S_TSDT] | fall[sbcirq_pkg::S_TSDT];
      grp[sbcirq_pkg::MG_IOCHG] = |chg[sbcirq_pkg::S_IO+:5];
      grp[sbcirq_pkg::MG_IOWAKE] = |rise[sbcirq_pkg::S_WAKE+:5];
      grp[sbcirq_pkg::MG_SPI] = frame_end && (count_r != sbcirq_pkg::FRAME_BITS);
   end
   assign any_event = |(grp & ~mask_r);

   // Pulse length picked from the configured width
   logic [sbcirq_pkg::PULSE_W-1:0] pulse_len;
   always_comb begin
      case (cfg_r[sbcirq_pkg::CFG_WIDTH_LSB+:2])
         2'h0: pulse_len = sbcirq_pkg::PULSE_W'(sbcirq_pkg::PULSE_CYC_0);
         2'h1: pulse_len = sbcirq_pkg::PULSE_W'(sbcirq_pkg::PULSE_CYC_1);
         2'h2: pulse_len = sbcirq_pkg::PULSE_W'(sbcirq_pkg::PULSE_CYC_2);
         default: pulse_len = sbcirq_pkg::PULSE_W'(sbcirq_pkg::PULSE_CYC_3);
      endcase
   end

   // Pending flag; an event in the pulse-start cycle stays pending and gives a further pulse
   sbcirq_pkg::sbcirq_state_t state_r;
   logic pending_r;
   logic [sbcirq_pkg::PULSE_W-1:0] pcnt_r;
   logic start;
   assign start = (state_r == sbcirq_pkg::SBCIRQ_IDLE) && pending_r;

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pending_r <= 1'b0;
      end else if (any_event && !cfg_r[sbcirq_pkg::CFG_OFF_BIT] &&
                   state_r == sbcirq_pkg::SBCIRQ_IDLE) begin
         pending_r <= 1'b1;
      end else if (start) begin
         pending_r <= 1'b0;
      end
   end

   // Pulse machine; events during a pulse merge into it
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_r <= sbcirq_pkg::SBCIRQ_IDLE;
         pcnt_r <= '0;
         irq_pulse_n_out <= 1'b1;
      end else begin
         case (state_r)
            sbcirq_pkg::SBCIRQ_IDLE: begin
               irq_pulse_n_out <= 1'b1;
               if (start) begin
                  state_r <= sbcirq_pkg::SBCIRQ_PULSE;
                  pcnt_r <= pulse_len - sbcirq_pkg::PULSE_W'(1);
                  irq_pulse_n_out <= 1'b0;
               end
            end
            sbcirq_pkg::SBCIRQ_PULSE: begin
               if (pcnt_r == '0) begin
                  state_r <= sbcirq_pkg::SBCIRQ_IDLE;
                  irq_pulse_n_out <= 1'b1;
               end else begin
                  pcnt_r <= pcnt_r - sbcirq_pkg::PULSE_W'(1);
               end
            end
            default: begin
               state_r <= sbcirq_pkg::SBCIRQ_IDLE;
               irq_pulse_n_out <= 1'b1;
            end
         endcase
      end
   end
endmodule : sbcirq_top
`default_nettype wire

/* File: pkg/sbcirq_pkg.sv */
// Constants shared by the interrupt pulse and fail-safe readback block
// Function
// - Impact field routes auxiliary undervoltage to outputs
// - Check bits mirror/invert impact field bits
// - Identification read frame returns global flags
// - Readback bit 1 shows deep safe setting
// - Readback bit 0 shows second output presence
// - Impact field and readback cleared by power-on
// - Unmasked event gives low interrupt pulse
// - Pulse behaviour and width set in init
// - Masked sources produce no interrupt pulse
// - Battery and supply low comparators raise events
// - Pre-regulator mode and activation changes raise events
// - Current-limit expiry event only with external pass
// - Regulator shutdowns and pass warnings raise events
// - Transceiver supply shutdown reported, auto restarted
// - General input state changes raise events
// - General input wake-ups raise events
// - Frame with clock count not 16 raises event
package sbcirq_pkg;
   // Frame layout
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] COUNT_MAX = 5'h1F;
   localparam logic [15:0] ID_READ_WORD = 16'h6800;
   localparam int CMD_MSB = 15;
   localparam int CMD_LSB = 9;
   localparam logic [6:0] AUX_WR_CMD = 7'h73;
   localparam logic [6:0] MASK_WR_CMD = 7'h75;
   localparam logic [6:0] CFG_WR_CMD = 7'h77;
   // Impact write frame fields
   localparam int AUX_OV_LSB = 6;
   localparam int AUX_UV_LSB = 4;
   localparam int SEC_B7 = 7;
   localparam int SEC_B6 = 6;
   localparam int SEC_B5 = 5;
   localparam int SEC_B4 = 4;
   localparam int SEC3 = 3;
   localparam int SEC2 = 2;
   localparam int SEC1 = 1;
   localparam int SEC0 = 0;
   // Impact encodings
   localparam logic [1:0] IMPACT_NONE = 2'h0;
   localparam logic [1:0] IMPACT_RST_ONLY = 2'h1;
   localparam logic [1:0] IMPACT_FS_ONLY = 2'h2;
   localparam logic [1:0] IMPACT_BOTH = 2'h3;
   localparam logic [1:0] IMPACT_RESET = 2'h0;
   localparam int IMPACT_RST_BIT = 0;
   localparam int IMPACT_FS_BIT = 1;
   // Readback layout
   localparam int RB_GLOBAL_LSB = 8;
   localparam int RB_DEEP_BIT = 1;
   localparam int RB_FS1_BIT = 0;
   // Interrupt configuration
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam int MG_SUPPLY = 0;
   localparam int MG_PREREG = 1;
   localparam int MG_CLIM = 2;
   localparam int MG_THERM = 3;
   localparam int MG_TRX = 4;
   localparam int MG_IOCHG = 5;
   localparam int MG_IOWAKE = 6;
   localparam int MG_SPI = 7;
   localparam int CFG_WIDTH_LSB = 0;
   localparam int CFG_OFF_BIT = 2;
   localparam logic [2:0] CFG_RESET = 3'h0;
   // Pulse widths
   localparam int unsigned CLK_KHZ = 10_000;
   localparam int unsigned PULSE_US_0 = 25;
   localparam int unsigned PULSE_US_1 = 50;
   localparam int unsigned PULSE_US_2 = 100;
   localparam int unsigned PULSE_US_3 = 200;
   localparam int unsigned PULSE_CYC_0 = (PULSE_US_0 * CLK_KHZ + 999) / 1000;
   localparam int unsigned PULSE_CYC_1 = (PULSE_US_1 * CLK_KHZ + 999) / 1000;
   localparam int unsigned PULSE_CYC_2 = (PULSE_US_2 * CLK_KHZ + 999) / 1000;
   localparam int unsigned PULSE_CYC_3 = (PULSE_US_3 * CLK_KHZ + 999) / 1000;
   localparam int PULSE_W = 12;
   // Synchronised input vector
   localparam int S_BATT = 0;
   localparam int S_SUPP = 1;
   localparam int S_BOOST = 2;
   localparam int S_PACT = 3;
   localparam int S_CLIMA = 4;
   localparam int S_CLIMX = 5;
   localparam int S_TSDA = 6;
   localparam int S_TSDX = 7;
   localparam int S_WARN = 8;
   localparam int S_TSDT = 9;
   localparam int S_IO = 10;
   localparam int S_WAKE = 15;
   localparam int S_AUXUV = 20;
   localparam int S_CS = 21;
   localparam int NSYNC = 22;
   localparam logic [NSYNC-1:0] SYNC_RESET = 22'h200000;
   // Interrupt pulse states
   typedef enum logic [1:0] {
      SBCIRQ_IDLE = 2'b01,
      SBCIRQ_PULSE = 2'b10
   } sbcirq_state_t;
endpackage : sbcirq_pkg

/* File: tb/sbcirq_host.sv */
// Host serial master model
`timescale 1ns/1ps
`default_nettype none
module sbcirq_host (
   output logic sclk_out,
   output logic cs_n_out,
   output logic mosi_out,
   input wire logic miso_in
);
   logic [15:0] rx_word;
   event got;
   // Idle: clock parked low, deselected
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
   end
   // One frame MSB first; the 48 ns clock runs only while selected
   task automatic frame(input logic [15:0] tx, input int nb);
      logic [15:0] sh;
      sh = tx;
      rx_word = 16'h0000;
      #7;
      cs_n_out = 1'b0;
      mosi_out = sh[15];
      #24;
      for (int k = 0; k < nb; k++) begin
         rx_word = {rx_word[14:0], miso_in}; // Settled bit, just before the rise
         sclk_out = 1'b1;
         #24;
         sclk_out = 1'b0;
         sh = sh << 1;
         mosi_out = sh[15];
         #24;
      end
      cs_n_out = 1'b1;
      mosi_out = ~mosi_out; // Released line must not look valid
      -> got;
      #800; // Gap lets the device judge the frame
   endtask : frame
endmodule : sbcirq_host
`default_nettype wire

/* File: tb/sbcirq_monitor.sv */
// Port checker for the interrupt pulse and readback block
`timescale 1ns/1ps
`default_nettype none
module sbcirq_monitor (
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic cs_n_in,
   input wire logic init_phase_in,
   input wire logic tsd_transceiver_in,
   input wire logic miso_oe_out,
   input wire logic irq_pulse_n_out,
   input wire logic aux_uv_reset_req_out,
   input wire logic aux_uv_failsafe_req_out,
   input wire logic transceiver_enable_out,
   input wire logic [1:0] aux_uv_impact_sel_out,
   input wire logic [1:0] aux_ov_impact_sel_out
);
   logic [11:0] low_cnt_r;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   // Length of the running low pulse; a stuck line trips the maximum first
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         low_cnt_r <= 12'h000;
      end else begin
         low_cnt_r <= irq_pulse_n_out ? 12'h000 : low_cnt_r + 12'h001;
      end
   end
   property p_pulse_len;
      $rose(irq_pulse_n_out) |-> low_cnt_r inside {12'h0FA, 12'h1F4, 12'h3E8, 12'h7D0};
   endproperty
   property p_pulse_max;
      low_cnt_r <= 12'h7D0;
   endproperty
   property p_gap;
      $rose(irq_pulse_n_out) |-> ##1 irq_pulse_n_out;
   endproperty
   property p_oe;
      miso_oe_out == !cs_n_in;
   endproperty
   property p_rst_req;
      aux_uv_reset_req_out |-> $past(aux_uv_impact_sel_out[0]);
   endproperty
   property p_fs_req;
      aux_uv_failsafe_req_out |-> $past(aux_uv_impact_sel_out[1]);
   endproperty
   property p_sel_init;
      $changed({aux_ov_impact_sel_out, aux_uv_impact_sel_out}) |-> $past(init_phase_in) && cs_n_in;
   endproperty
   property p_trx_off;
      tsd_transceiver_in [*7] |-> !transceiver_enable_out;
   endproperty
   property p_trx_on;
      (!tsd_transceiver_in) [*7] |-> transceiver_enable_out;
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("interrupt pulse width off table");
   a_pulse_max: assert property (p_pulse_max)
      else $error("interrupt pulse too long");
   a_gap: assert property (p_gap)
      else $error("interrupt line not high between pulses");
   a_oe: assert property (p_oe)
      else $error("serial output enable not tied to select");
   a_rst_req: assert property (p_rst_req)
      else $error("reset request without impact bit");
   a_fs_req: assert property (p_fs_req)
      else $error("fail-safe request without impact bit");
   a_sel_init: assert property (p_sel_init)
      else $error("impact field changed outside init");
   a_trx_off: assert property (p_trx_off)
      else $error("transceiver supply kept on in shutdown");
   a_trx_on: assert property (p_trx_on)
      else $error("transceiver supply not restarted");
   c_pulse: cover property ($fell(irq_pulse_n_out));
   c_write: cover property ($changed(aux_uv_impact_sel_out));
   c_trx: cover property ($fell(transceiver_enable_out));
endmodule : sbcirq_monitor
bind sbcirq_top sbcirq_monitor i_mon (
   .mclk_in(mclk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in), .init_phase_in(init_phase_in),
   .tsd_transceiver_in(tsd_transceiver_in), .miso_oe_out(miso_oe_out),
   .irq_pulse_n_out(irq_pulse_n_out), .aux_uv_reset_req_out(aux_uv_reset_req_out),
   .aux_uv_failsafe_req_out(aux_uv_failsafe_req_out),
   .transceiver_enable_out(transceiver_enable_out),
   .aux_uv_impact_sel_out(aux_uv_impact_sel_out), .aux_ov_impact_sel_out(aux_ov_impact_sel_out));
`default_nettype wire

/* File: tb/sbcirq_top_test.sv */
// Self-checking bench for the interrupt pulse and readback block
`timescale 1ns/1ps
`default_nettype none
module sbcirq_top_test;
   localparam logic SSP = 1'b0;
   logic mclk_in = 1'b0;
   logic rstn_in = 1'b1;
   logic init_phase = 1'b1;
   logic [7:0] flags = 8'h00;
   logic deep = 1'b0;
   logic aux_uv = 1'b0;
   logic ext_pass = 1'b1;
   logic [19:0] ev = 20'h00000;
   logic sclk, cs_n, mosi, miso, miso_oe, irq_n, rst_req, fs_req, trx_en;
   logic [1:0] uv_sel, ov_sel, uv, ov;
   logic [15:0] exp_rd[$];
   int unsigned exp_w[$];
   int unsigned wt[4] = '{sbcirq_pkg::PULSE_CYC_0, sbcirq_pkg::PULSE_CYC_1,
                          sbcirq_pkg::PULSE_CYC_2, sbcirq_pkg::PULSE_CYC_3};
   int mismatches = 0;
   int cmp_count = 0;
   always #50 mclk_in = ~mclk_in;
   // Pass strap starts fitted so current-limit events are live
   sbcirq_top #(.SECOND_SAFE_PRESENT(SSP)) i_dut (
      .mclk_in(mclk_in), .rstn_in(rstn_in), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi),
      .miso_out(miso), .miso_oe_out(miso_oe), .init_phase_in(init_phase),
      .global_flags_in(flags), .deep_safe_hw_in(deep), .ext_pass_fitted_in(ext_pass),
      .battery_low_in(ev[0]), .supply_low_in(ev[1]), .prereg_boost_in(ev[2]),
      .prereg_active_in(ev[3]), .clim_expire_analog_in(ev[4]), .clim_expire_aux_in(ev[5]),
      .tsd_analog_in(ev[6]), .tsd_aux_in(ev[7]), .pass_warn_in(ev[8]),
      .tsd_transceiver_in(ev[9]), .io_state_in(ev[14:10]), .io_wake_in(ev[19:15]),
      .aux_uv_in(aux_uv), .irq_pulse_n_out(irq_n), .aux_uv_reset_req_out(rst_req),
      .aux_uv_failsafe_req_out(fs_req), .transceiver_enable_out(trx_en),
      .aux_uv_impact_sel_out(uv_sel), .aux_ov_impact_sel_out(ov_sel));
   sbcirq_host i_host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask : cyc
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // Every answer carries the identification word, cut short on short frames
   task automatic xfer(input logic [15:0] tx, input int nb);
      exp_rd.push_back({flags, 6'h00, deep, SSP} >> (16 - nb));
      i_host.frame(tx, nb);
   endtask : xfer
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up
   // Answer words in send order
   always @(i_host.got) begin
      chk(i_host.rx_word, exp_rd.pop_front());
   end
   // Low pulse length against the oldest expected width; none expected means zero
   always @(negedge irq_n) begin : irq_watch
      int unsigned n;
      n = 0;
      while (irq_n === 1'b0) begin
         @(posedge mclk_in);
         #1;
         n++;
      end
      chk(16'(n), exp_w.size() ? 16'(exp_w.pop_front()) : 16'h0000);
   end
   // Hang guard, well beyond the planned run
   initial begin
      cyc(40000);
      mismatches++;
      wrap_up();
   end
   initial begin
      rstn_in <= 1'b0; // A real falling edge also clears the link-side flops
      void'($urandom(78197));
      flags <= 8'($urandom);
      deep <= 1'($urandom);
      cyc(3);
      rstn_in <= 1'b1;
      cyc(8);
      xfer(16'h6800, 16);
      $display("identification read done");
      for (int c = 0; c < 4; c++) begin
         uv = 2'(c);
         ov = 2'($urandom);
         xfer({7'h73, 1'b0, ov, uv, ~uv, ov}, 16);
         chk(16'(uv_sel), 16'(uv));
         chk(16'(ov_sel), 16'(ov));
         @(posedge mclk_in);
         aux_uv <= 1'b1;
         cyc(8);
         chk(16'({fs_req, rst_req}), 16'(uv));
         aux_uv <= 1'b0;
      end
      xfer({7'h73, 1'b0, ov, 2'h0, 2'h0, ov}, 16); // Bad check bits
      @(posedge mclk_in);
      init_phase <= 1'b0;
      xfer({7'h73, 1'b0, ov, 2'h1, 2'h2, ov}, 16); // Outside init
      chk(16'(uv_sel), 16'h0003);
      @(posedge mclk_in);
      init_phase <= 1'b1;
      $display("impact test done");
      xfer({7'h75, 9'h000}, 16);
      for (int w = 0; w < 5; w++) begin
         xfer({7'h77, 9'(w % 4)}, 16);
         if (w == 4) break;
         exp_w.push_back(wt[w]);
         @(posedge mclk_in);
         ev[0] <= 1'b1;
         cyc(2300);
         ev[0] <= 1'b0;
         cyc(10);
      end
      exp_w.push_back(wt[0]);
      @(posedge mclk_in);
      ev[0] <= 1'b1;
      cyc(20);
      ev[1] <= 1'b1; // Lands inside the pulse, merged
      cyc(600);
      for (int i = 2; i < 20; i++) begin
         exp_w.push_back(wt[0]);
         ev[i] <= 1'b1;
         cyc(300);
      end
      chk(16'(trx_en), 16'h0000);
      $display("event test done");
      xfer({7'h75, 9'h0FF}, 16);
      @(posedge mclk_in);
      ev <= 20'h00000; // Masked: no pulse may follow
      cyc(300);
      chk(16'(trx_en), 16'h0001);
      xfer({7'h75, 9'h000}, 16);
      xfer({7'h77, 9'h004}, 16); // Pulses switched off
      @(posedge mclk_in);
      ev[0] <= 1'b1; // No pulse may follow
      cyc(300);
      ev[0] <= 1'b0;
      xfer({7'h77, 9'h000}, 16);
      exp_w.push_back(wt[0]);
      xfer(16'h6800, 15);
      cyc(300);
      $display("mask and frame count test done");
      @(posedge mclk_in);
      rstn_in <= 1'b0;
      deep <= ~deep;
      ext_pass <= 1'b0; // Strap caught again at release
      cyc(3);
      rstn_in <= 1'b1;
      cyc(8);
      chk(16'({ov_sel, uv_sel}), 16'h0000);
      xfer(16'h6800, 16);
      @(posedge mclk_in);
      ev[4] <= 1'b1; // No pass fitted: no pulse may follow
      cyc(300);
      exp_w.push_back(wt[0]);
      ev[0] <= 1'b1; // Width back at its reset value
      cyc(300);
      chk(16'(exp_w.size()), 16'h0000); // Every expected pulse seen
      $display("power-on reset test done");
      wrap_up();
   end
endmodule : sbcirq_top_test
`default_nettype wire
